// [pspg_top.sv]
// power-down sequencer, power-good outputs, pushbutton monitor and wake logic
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps

// Overview of operation
// RL1: power-down disables strobe 7 first, then 6 after step delay 6, down to 1
// RL2: instant shutdown bit skips all delays and drops sequenced rails together
// RL3: power-down starts on trigger bit, hold low, long press, reset pin or fault
// RL4: going to OFF, unassigned rails are dropped after the sequence finishes
// RL5: going to SLEEP, rails outside the sequencer keep their state
// RL6: strobes 14 and 15 belong only to the two linear rails
// RL7: strobe 14 fires on wake event, strobe 15 one step delay 6 later
// RL8: on power-down, strobes 15 then 14 run only when going to OFF (OFF bit, long press, reset pin or fault)
// RL9: a monitored rail losing power-good is a fault: all rails off, enter OFF
// RL10: power-good outputs reset low, low with all rails off, unaffected by single disables
// RL11: disabled rails ignored; monitoring of a rail starts 5 ms after enable
// RL12: both power-good outputs wait the programmable delay after sequencing
// RL13: aux power-good high while a linear rail is on and healthy
// RL14: main power-good watches bucks, and switch rails only in regulator mode
// RL15: linear rails count toward main power-good only with mask cleared
// RL16: main power-good low in SLEEP and hold wait, high after delay in ACTIVE
// RL17: faults of switch rails in load-switch mode are ignored
// RL18: pushbutton deglitched 50 ms; a press powers up from OFF or SLEEP
// RL19: pushbutton held over 8 s power cycles the device
// RL20: every debounced button change sets its flag; status shows the level
// RL21: wake output low 50 ms after wake event, released 50 ms after hold
// RL22: hold still low 5 s after wake output falls shuts down by OFF bit
// RL23: rails with strobe field zero take no part in sequencing
// RL24: each step delay is clamped between 1 ms and 10 ms
// RL25: the trigger bit clears itself when its power-down finishes
module pspg_top import pspg_pkg::*; #(
	parameter logic [16:0] TICK_CYCLES_P = 17'(TICK_CYCLES)
) (
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic PUSHBUTTON_IN_N_I,
	input wire logic POWER_HOLD_IN_I,
	input wire logic HW_RESET_N_I,
	input wire logic OVERTEMP_SHUTDOWN_I,
	input wire logic UNDERVOLTAGE_LOCKOUT_I,
	input wire logic USB_PRESENT_I,
	input wire logic AC_PRESENT_I,
	input wire logic [NRAIL-1:0] RAIL_PG_I,
	input wire logic [2:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WE_I,
	input wire logic REG_RE_I,
	output logic [31:0] REG_RDATA_O,
	output logic [NRAIL-1:0] RAIL_EN_O,
	output logic MAIN_POWER_GOOD_O,
	output logic AUX_POWER_GOOD_O,
	output logic WAKE_OUT_N_O,
	output logic WAKE_OUT_OE_O
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [NRAIL-1:0] rails_at(input logic [27:0] asg, input logic [3:0] s);
		logic [NRAIL-1:0] r;
		r = '0;
		for (int i = 0; i < NRAIL; i++) begin
			r[i] = (s != 4'h0) && (asg[4*i +: 4] == s); // RL23
		end
		return r;
	endfunction

	function automatic logic [NRAIL-1:0] seq_rails(input logic [27:0] asg);
		logic [NRAIL-1:0] r;
		r = '0;
		for (int i = 0; i < NRAIL; i++) begin
			r[i] = (asg[4*i +: 4] != 4'h0) && (asg[4*i +: 4] <= {1'b0, STB_LAST}); // RL23
		end
		return r;
	endfunction

	function automatic logic [12:0] step_ms(input logic [23:0] d, input logic [2:0] k);
		logic [3:0] v;
		v = d[4*(k-3'h1) +: 4];
		if (v < STEP_MIN) begin
			v = STEP_MIN; // RL24
		end else if (v > STEP_MAX) begin
			v = STEP_MAX; // RL24
		end
		return {9'h000, v};
	endfunction

	// ----------------------------------------------------------------
	// rail monitoring
	// ----------------------------------------------------------------
	pspg_regs_s q, n;
	logic [NRAIL-1:0] pg, mon, ls_ign, main_set;
	logic hold, rst_ok, hazard, fault, main_bad, lin_bad;

	assign pg = q.flt[I_PG +: NRAIL];
	assign hold = q.flt[I_HOLD];
	assign rst_ok = q.flt[I_RSTN];
	assign ls_ign = SW_RAILS & {2'b00, ~q.ctrl[CTRL_LSB_REG], ~q.ctrl[CTRL_LSA_REG], 3'b000}; // RL17
	assign main_set = BUCK_RAILS | (SW_RAILS & ~ls_ign) // RL14
		| (LIN_RAILS & {~q.pgmask[1], ~q.pgmask[0], 5'h00}); // RL15

	always_comb begin
		for (int i = 0; i < NRAIL; i++) begin
			mon[i] = q.en[i] && (q.blank[3*i +: 3] == BLANK_DONE); // RL11
		end
	end

	assign fault = |(mon & ~pg & ~ls_ign); // RL9
	assign main_bad = |(mon & ~pg & main_set);
	assign lin_bad = |(mon & ~pg & LIN_RAILS);
	assign hazard = !rst_ok || q.flt[I_OTS] || q.flt[I_UNDERVOLTAGE_LOCKOUT] || fault; // RL3

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic pb_chg, pb_fall, long_ev, wake_ev, go_down, down_off, clr_trig, main_done;
		pb_chg = 1'b0;
		pb_fall = 1'b0;
		long_ev = 1'b0;
		wake_ev = 1'b0;
		go_down = 1'b0;
		down_off = 1'b0;
		clr_trig = 1'b0;
		main_done = 1'b0;
		n = q;
		n.tick = 1'b0;
		n.s1 = {RAIL_PG_I, AC_PRESENT_I, USB_PRESENT_I, UNDERVOLTAGE_LOCKOUT_I,
			OVERTEMP_SHUTDOWN_I, HW_RESET_N_I, POWER_HOLD_IN_I, PUSHBUTTON_IN_N_I};
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int i = 0; i < NIN; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.flt[i] = q.s3[i];
			end
		end
		// 1 ms tick
		if (q.div == TICK_CYCLES_P - 17'h1) begin
			n.div = '0;
			n.tick = 1'b1;
		end else begin
			n.div = q.div + 17'h1;
		end
		// pushbutton deglitch and long press
		if (q.flt[I_PB] == q.pb_lvl) begin
			n.db_cnt = '0;
		end else if (q.tick) begin
			if (q.db_cnt == DB_LAST) begin // RL18
				n.db_cnt = '0;
				n.pb_lvl = q.flt[I_PB];
				pb_chg = 1'b1; // RL20
				pb_fall = !q.flt[I_PB];
			end else begin
				n.db_cnt = q.db_cnt + 6'h1;
			end
		end
		if (q.pb_lvl) begin
			n.lp_cnt = '0;
			n.lp_done = 1'b0;
		end else if (q.tick && !q.lp_done) begin
			if (q.lp_cnt == LP_LAST) begin
				long_ev = 1'b1; // RL19
				n.lp_done = 1'b1;
			end else begin
				n.lp_cnt = q.lp_cnt + 13'h1;
			end
		end
		wake_ev = pb_fall || (n.flt[I_USB] && !q.flt[I_USB]) || (n.flt[I_AC] && !q.flt[I_AC]);
		// power-good blanking after enable
		for (int i = 0; i < NRAIL; i++) begin
			if (!q.en[i]) begin
				n.blank[3*i +: 3] = '0;
			end else if (q.tick && q.blank[3*i +: 3] != BLANK_DONE) begin
				n.blank[3*i +: 3] = q.blank[3*i +: 3] + 3'h1; // RL11
			end
		end
		// wake release timer
		if (q.wr_act && q.tick) begin
			if (q.wr_cnt == WREL_LAST) begin
				n.wr_act = 1'b0; // RL21
			end else begin
				n.wr_cnt = q.wr_cnt + 6'h1;
			end
		end
		unique case (q.st)
			ST_OFF: begin
				if (wake_ev && rst_ok && !q.flt[I_OTS] && !q.flt[I_UNDERVOLTAGE_LOCKOUT]) begin // RL18
					n.st = ST_WAKE;
					n.tmr = '0;
					n.en = q.en | rails_at(q.asg, STB_AON_A); // RL7
				end
			end
			ST_WAKE: begin
				if (q.tick && q.tmr != TMR_MAX) begin
					n.tmr = q.tmr + 13'h1;
				end
				if (q.tick && q.tmr == step_ms(q.stepd, STB_STEP_DELAY_6)) begin
					n.en = q.en | rails_at(q.asg, STB_AON_B); // RL7
				end
				if (hold && q.wake_oe) begin
					n.st = ST_UP;
					n.stb = STB_FIRST;
					n.tmr = '0;
					n.wr_act = 1'b1; // RL21
					n.wr_cnt = '0;
				end else if (q.tmr >= WAKE_TMO) begin
					go_down = 1'b1; // RL22
					down_off = q.ctrl[CTRL_OFF]; // RL22
				end
				if (hazard) begin
					go_down = 1'b1;
					down_off = 1'b1;
				end
			end
			ST_UP: begin
				if (q.tmr == '0) begin
					n.en = q.en | rails_at(q.asg, {1'b0, q.stb});
					if (q.stb == STB_LAST) begin
						n.st = ST_ACTIVE;
						n.seq_done = 1'b1;
						n.pgd_cnt = '0;
					end else begin
						n.tmr = 13'h1;
					end
				end else if (q.tick) begin
					if (q.tmr == step_ms(q.stepd, q.stb)) begin
						n.stb = q.stb + 3'h1;
						n.tmr = '0;
					end else begin
						n.tmr = q.tmr + 13'h1;
					end
				end
				if (hazard) begin
					go_down = 1'b1;
					down_off = 1'b1;
				end
			end
			ST_ACTIVE: begin
				if (!q.pgd_done && q.tick) begin
					n.pgd_cnt = q.pgd_cnt + 8'h1;
					if ({1'b0, q.pgd_cnt} + 9'h001 >= {1'b0, q.power_good_delay}) begin
						n.pgd_done = 1'b1; // RL12
						n.aux_arm = 1'b1;
					end
				end
				if (q.ctrl[CTRL_TRIG] || !hold) begin
					go_down = 1'b1; // RL3
					down_off = q.ctrl[CTRL_OFF];
				end
				if (long_ev) begin
					go_down = 1'b1;
					down_off = 1'b1;
					n.cycle = 1'b1; // RL19
				end
				if (hazard) begin
					go_down = 1'b1; // RL9
					down_off = 1'b1;
				end
			end
			ST_DOWN: begin
				if (q.ctrl[CTRL_INST]) begin
					n.en = q.en & ~seq_rails(q.asg); // RL2
					main_done = 1'b1;
				end else if (q.tmr == '0) begin
					n.en = q.en & ~rails_at(q.asg, {1'b0, q.stb}); // RL1
					if (q.stb == STB_FIRST) begin
						main_done = 1'b1;
					end else begin
						n.tmr = 13'h1;
					end
				end else if (q.tick) begin
					if (q.tmr == step_ms(q.stepd, q.stb - 3'h1)) begin
						n.stb = q.stb - 3'h1; // RL1
						n.tmr = '0;
					end else begin
						n.tmr = q.tmr + 13'h1;
					end
				end
				if (main_done) begin
					n.tmr = '0;
					if (q.tgt_off) begin
						n.st = ST_AON_DN; // RL8
					end else begin
						n.st = ST_SLEEP; // RL5
						clr_trig = 1'b1;
					end
				end
			end
			ST_AON_DN: begin
				if (q.tmr == '0) begin
					n.en = q.en & ~rails_at(q.asg, STB_AON_B); // RL8
					n.tmr = 13'h1;
				end else if (q.ctrl[CTRL_INST] || (q.tick && q.tmr == step_ms(q.stepd, STB_STEP_DELAY_6))) begin
					n.en = '0; // RL4
					clr_trig = 1'b1;
					n.seq_done = 1'b0;
					n.pgd_done = 1'b0;
					n.aux_arm = 1'b0;
					n.cycle = 1'b0;
					n.tmr = '0;
					if (q.cycle) begin
						n.st = ST_WAKE; // RL19
						n.en = rails_at(q.asg, STB_AON_A);
					end else begin
						n.st = ST_OFF;
					end
				end else if (q.tick) begin
					n.tmr = q.tmr + 13'h1;
				end
			end
			ST_SLEEP: begin
				if (hold) begin
					n.st = ST_UP;
					n.stb = STB_FIRST;
					n.tmr = '0;
					n.pgd_done = 1'b0;
				end else if (wake_ev) begin
					n.st = ST_WAKE; // RL18
					n.tmr = '0;
					n.en = q.en | rails_at(q.asg, STB_AON_A);
				end
				if (hazard) begin
					go_down = 1'b1;
					down_off = 1'b1;
				end
			end
			default: begin
				n.st = ST_OFF;
			end
		endcase
		if (go_down) begin
			n.st = ST_DOWN;
			n.stb = STB_LAST; // RL1
			n.tmr = '0;
			n.tgt_off = down_off;
			n.seq_done = 1'b0;
			n.pgd_done = 1'b0;
		end
		if (clr_trig) begin
			n.ctrl[CTRL_TRIG] = 1'b0; // RL25
		end
		// register writes
		if (REG_WE_I) begin
			unique case (REG_ADDR_I)
				A_CTRL: n.ctrl = REG_WDATA_I[4:0];
				A_PGCFG: begin
					n.pgmask = REG_WDATA_I[1:0];
					n.power_good_delay = REG_WDATA_I[PGC_DLY_LSB +: 8];
				end
				A_ASSIGN: begin
					for (int i = 0; i < NRAIL; i++) begin
						n.asg[4*i +: 4] = REG_WDATA_I[4*i +: 4];
						if (!LIN_RAILS[i] && REG_WDATA_I[4*i +: 4] >= STB_AON_A) begin
							n.asg[4*i +: 4] = 4'h0; // RL6
						end
					end
				end
				A_STEP: n.stepd = REG_WDATA_I[23:0];
				A_ENABLE: begin
					if (q.st == ST_ACTIVE || q.st == ST_SLEEP) begin
						n.en = REG_WDATA_I[NRAIL-1:0];
					end
				end
				A_IRQ: n.irq_pb = q.irq_pb & ~REG_WDATA_I[0];
				default: begin
				end
			endcase
		end
		n.irq_pb = n.irq_pb | pb_chg; // RL20
		// register reads
		n.rdata = '0;
		if (REG_RE_I) begin
			unique case (REG_ADDR_I)
				A_CTRL: n.rdata = {27'h0, q.ctrl};
				A_PGCFG: n.rdata = {16'h0, q.power_good_delay, 6'h0, q.pgmask};
				A_ASSIGN: n.rdata = {4'h0, q.asg};
				A_STEP: n.rdata = {8'h0, q.stepd};
				A_ENABLE: n.rdata = {25'h0, q.en};
				A_STATUS: n.rdata = {17'h0, q.st, 3'h0, q.wake_oe, q.seq_done, q.aux_pg,
					q.main_pg, q.pb_lvl}; // RL20
				A_IRQ: n.rdata = {31'h0, q.irq_pb};
				default: n.rdata = '0;
			endcase
		end
		// outputs
		n.main_pg = (q.st == ST_ACTIVE) && q.pgd_done && |(q.en & main_set) && !main_bad; // RL16
		// kept through power-down: only the linear rails themselves drop it
		n.aux_pg = (q.st == ST_ACTIVE || q.st == ST_SLEEP || q.st == ST_UP || q.st == ST_DOWN
			|| q.st == ST_AON_DN) && q.aux_arm && |(q.en & LIN_RAILS) && !lin_bad; // RL13 RL10
		n.wake_oe = (n.st == ST_WAKE && n.tmr >= WAKE_DLY) || n.wr_act; // RL21
		n.wake_n = !n.wake_oe;
		if (SYS_RST_I) begin
			n = '0; // RL10
			n.st = ST_OFF;
			n.s1 = IN_RST;
			n.s2 = IN_RST;
			n.s3 = IN_RST;
			n.flt = IN_RST;
			n.pb_lvl = 1'b1;
			n.ctrl = CTRL_RST;
			n.pgmask = PGMASK_RST; // RL15
			n.power_good_delay = POWER_GOOD_DELAY_RST;
			n.asg = ASSIGN_RST;
			n.stepd = STEP_RST;
			n.wake_n = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		q <= n;
	end

	assign REG_RDATA_O = q.rdata;
	assign RAIL_EN_O = q.en;
	assign MAIN_POWER_GOOD_O = q.main_pg;
	assign AUX_POWER_GOOD_O = q.aux_pg;
	assign WAKE_OUT_N_O = q.wake_n;
	assign WAKE_OUT_OE_O = q.wake_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	property p_down_start;
		$rose(q.st == ST_DOWN) |-> q.stb == STB_LAST && q.tmr == 13'h0;
	endproperty
	a_down_start: assert property (p_down_start) else $error("power-down not at strobe 7"); // RL1

	property p_instant;
		(q.st == ST_DOWN && q.ctrl[CTRL_INST]) |=> (q.en & seq_rails(q.asg)) == 7'h00;
	endproperty
	a_instant: assert property (p_instant) else $error("instant shutdown left rails on"); // RL2

	property p_hold_drop;
		(q.st == ST_ACTIVE && !hold) |=> q.st == ST_DOWN;
	endproperty
	a_hold_drop: assert property (p_hold_drop) else $error("hold low did not start power-down"); // RL3

	property p_off_empty;
		$rose(q.st == ST_OFF) |-> q.en == 7'h00;
	endproperty
	a_off_empty: assert property (p_off_empty) else $error("rails left on in OFF"); // RL4

	property p_aon_keep;
		(q.st == ST_DOWN && !q.tgt_off) |=> $stable(q.en & LIN_RAILS & ~seq_rails(q.asg));
	endproperty
	a_aon_keep: assert property (p_aon_keep) else $error("always-on rails touched"); // RL8

	property p_fault;
		(q.st == ST_ACTIVE && fault) |=> q.st == ST_DOWN && q.tgt_off;
	endproperty
	a_fault: assert property (p_fault) else $error("fault did not force OFF"); // RL9

	property p_pg_all_off;
		q.en == 7'h00 |=> !q.main_pg && !q.aux_pg;
	endproperty
	a_pg_all_off: assert property (p_pg_all_off) else $error("power-good high with no rails"); // RL10

	property p_main_forced;
		(q.st == ST_SLEEP || q.st == ST_WAKE) |=> !q.main_pg;
	endproperty
	a_main_forced: assert property (p_main_forced) else $error("main power-good in sleep"); // RL16

	property p_pb_flag;
		$changed(q.pb_lvl) |-> q.irq_pb;
	endproperty
	a_pb_flag: assert property (p_pb_flag) else $error("button change lost"); // RL20

	property p_wake_active;
		(q.st == ST_ACTIVE && !q.wr_act) |=> q.wake_n;
	endproperty
	a_wake_active: assert property (p_wake_active) else $error("wake low in ACTIVE"); // RL21

	property p_trig_clear;
		(q.st == ST_AON_DN && n.st != ST_AON_DN && !REG_WE_I) |=> !q.ctrl[CTRL_TRIG];
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger bit not cleared"); // RL25

	c_to_off: cover property ($rose(q.st == ST_OFF));
	c_to_sleep: cover property ($rose(q.st == ST_SLEEP));
	c_main_pg: cover property ($rose(q.main_pg));
	c_cycle: cover property (q.cycle && q.st == ST_AON_DN ##1 q.st == ST_WAKE);
endmodule

// [pspg_pkg.sv]
// constants, register map, state and storage types of the power sequencer block
package pspg_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_DEGLITCH_MS = 50;
	localparam int T_LONG_PRESS_S = 8;
	localparam int T_HOLD_TIMEOUT_S = 5;
	localparam int T_WAKE_DELAY_MS = 50;
	localparam int T_WAKE_RELEASE_MS = 50;
	localparam int T_PG_BLANK_MS = 5;
	localparam int T_STEP_MIN_MS = 1;
	localparam int T_STEP_MAX_MS = 10;
	localparam logic [5:0] DB_LAST = 6'(T_DEGLITCH_MS - 1);
	localparam logic [12:0] LP_LAST = 13'(T_LONG_PRESS_S * 1000 - 1);
	localparam logic [12:0] WAKE_DLY = 13'(T_WAKE_DELAY_MS);
	localparam logic [12:0] WAKE_TMO = 13'(T_WAKE_DELAY_MS + T_HOLD_TIMEOUT_S * 1000);
	localparam logic [5:0] WREL_LAST = 6'(T_WAKE_RELEASE_MS - 1);
	localparam logic [2:0] BLANK_DONE = 3'(T_PG_BLANK_MS);
	localparam logic [3:0] STEP_MIN = 4'(T_STEP_MIN_MS);
	localparam logic [3:0] STEP_MAX = 4'(T_STEP_MAX_MS);
	localparam logic [12:0] TMR_MAX = 13'h1fff;

	// ----------------------------------------------------------------
	// rails, strobes and synchronised inputs
	// ----------------------------------------------------------------
	localparam int NRAIL = 7;
	localparam logic [6:0] BUCK_RAILS = 7'h07;
	localparam logic [6:0] SW_RAILS = 7'h18;
	localparam logic [6:0] LIN_RAILS = 7'h60;
	localparam logic [2:0] STB_FIRST = 3'h1;
	localparam logic [2:0] STB_LAST = 3'h7;
	localparam logic [2:0] STB_STEP_DELAY_6 = 3'h6;
	localparam logic [3:0] STB_AON_A = 4'he;
	localparam logic [3:0] STB_AON_B = 4'hf;
	localparam int NIN = 14;
	localparam int I_PB = 0;
	localparam int I_HOLD = 1;
	localparam int I_RSTN = 2;
	localparam int I_OTS = 3;
	localparam int I_UNDERVOLTAGE_LOCKOUT = 4;
	localparam int I_USB = 5;
	localparam int I_AC = 6;
	localparam int I_PG = 7;
	localparam logic [13:0] IN_RST = 14'h0005;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_PGCFG = 3'h1;
	localparam logic [2:0] A_ASSIGN = 3'h2;
	localparam logic [2:0] A_STEP = 3'h3;
	localparam logic [2:0] A_ENABLE = 3'h4;
	localparam logic [2:0] A_STATUS = 3'h5;
	localparam logic [2:0] A_IRQ = 3'h6;
	localparam int CTRL_TRIG = 0;
	localparam int CTRL_INST = 1;
	localparam int CTRL_OFF = 2;
	localparam int CTRL_LSA_REG = 3;
	localparam int CTRL_LSB_REG = 4;
	localparam int PGC_DLY_LSB = 8;
	localparam logic [4:0] CTRL_RST = 5'h04;
	localparam logic [1:0] PGMASK_RST = 2'h3;
	localparam logic [7:0] POWER_GOOD_DELAY_RST = 8'h14;
	localparam logic [27:0] ASSIGN_RST = 28'hfe54321;
	localparam logic [23:0] STEP_RST = 24'h222222;

	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_WAKE = 7'h02,
		ST_UP = 7'h04,
		ST_ACTIVE = 7'h08,
		ST_DOWN = 7'h10,
		ST_AON_DN = 7'h20,
		ST_SLEEP = 7'h40
	} pspg_state_e;

	typedef struct packed {
		pspg_state_e st;
		logic [NIN-1:0] s1, s2, s3, flt;
		logic [16:0] div;
		logic tick;
		logic [5:0] db_cnt;
		logic pb_lvl;
		logic [12:0] lp_cnt;
		logic lp_done;
		logic [12:0] tmr;
		logic [2:0] stb;
		logic [5:0] wr_cnt;
		logic wr_act;
		logic tgt_off, cycle, seq_done, pgd_done, aux_arm;
		logic [7:0] pgd_cnt;
		logic [3*NRAIL-1:0] blank;
		logic [NRAIL-1:0] en;
		logic [4:0] ctrl;
		logic [1:0] pgmask;
		logic [7:0] power_good_delay;
		logic [27:0] asg;
		logic [23:0] stepd;
		logic irq_pb;
		logic [31:0] rdata;
		logic main_pg, aux_pg, wake_oe, wake_n;
	} pspg_regs_s;
endpackage

// [pspg_host.sv]
// host processor and rail model facing the power sequencer
`timescale 1ns/10ps
module pspg_host #(
	parameter int LAG = 30
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wake_pin_i,
	input wire logic cmd_i,
	input wire logic eager_i,
	input wire logic [6:0] en_i,
	input wire logic [6:0] fault_i,
	output logic hold_o,
	output logic [6:0] pg_o
);
	int cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_o <= 1'b0;
			cnt <= 0;
			pg_o <= 7'h00;
		end else begin
			pg_o <= en_i & ~fault_i;
			if (!cmd_i) begin
				hold_o <= 1'b0;
				cnt <= 0;
			end else if (eager_i) begin
				hold_o <= 1'b1;
			end else if (!wake_pin_i) begin
				if (cnt == LAG) begin
					hold_o <= 1'b1;
				end else begin
					cnt <= cnt + 1;
				end
			end
		end
	end
endmodule

// [pspg_tb.sv]
// self-checking testbench of the power sequencer block
`timescale 1ns/10ps
module tb import pspg_pkg::*;;
	logic clk = 0, rst = 1, pb_n = 1, usb = 0, we = 0, re = 0, cmd = 0, eager = 0;
	logic [2:0] addr = 0;
	logic [31:0] wdata = 0, rd_q;
	logic [6:0] fault = 0;
	logic hw_rst_n = 1;
	wire logic hold, main_pg, aux_pg, wake_n, wake_oe, wake_pin;
	wire logic [6:0] en, pg;
	wire logic [31:0] rdata;
	int fail_count = 0, samples_checked = 0;
	time t0, t1;
	logic [2:0] ra[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [31:0] rv[5] = '{32'h4, 32'h1403, 32'h0fe54321, 32'h222222, 32'h0};

	always #5 clk = ~clk;
	assign wake_pin = wake_oe ? wake_n : 1'b1;

	pspg_top #(.TICK_CYCLES_P(17'd10)) dut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
		.PUSHBUTTON_IN_N_I(pb_n), .POWER_HOLD_IN_I(hold), .HW_RESET_N_I(hw_rst_n),
		.OVERTEMP_SHUTDOWN_I(1'b0), .UNDERVOLTAGE_LOCKOUT_I(1'b0), .USB_PRESENT_I(usb),
		.AC_PRESENT_I(1'b0), .RAIL_PG_I(pg), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdata), .RAIL_EN_O(en),
		.MAIN_POWER_GOOD_O(main_pg), .AUX_POWER_GOOD_O(aux_pg), .WAKE_OUT_N_O(wake_n),
		.WAKE_OUT_OE_O(wake_oe));

	pspg_host host (.clk_i(clk), .rst_i(rst), .wake_pin_i(wake_pin), .cmd_i(cmd),
		.eager_i(eager), .en_i(en), .fault_i(fault), .hold_o(hold), .pg_o(pg));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 rd_q = rdata;
	endtask

	function automatic bit cond(input int s);
		case (s)
			0: return en[5] === 1'b1;
			1: return en[6] === 1'b1;
			2: return wake_oe === 1'b1;
			3: return wake_oe === 1'b0;
			4: return main_pg === 1'b1;
			5: return en !== 7'h7f;
			6: return en !== 7'h6f;
			7: return en[4:0] === 5'h00;
			8: return en === 7'h00;
			9: return hold === 1'b1;
			10: return en === 7'h7f;
			default: return 1'b0;
		endcase
	endfunction

	task automatic wt(input int s, input int lim);
		int n;
		n = 0;
		#1;
		while (!cond(s) && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			chk(32'h0, 32'h1);
		end
	endtask

	task automatic rng(input time ts, input int lo, input int hi);
		int n;
		n = int'(($time - ts) / 10);
		chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({25'h0, en}, 32'h0);
		chk({30'h0, main_pg, aux_pg}, 32'h0);
		chk({30'h0, wake_n, wake_oe}, 32'h2);
		for (int i = 0; i < 5; i++) begin
			rd(ra[i]);
			chk(rd_q, rv[i]);
		end
		@(posedge clk);
		cmd <= 1'b1;
		pb_n <= 1'b0;
		wt(0, 800);
		t0 = $time;
		chk({25'h0, en}, 32'h20);
		wt(1, 100);
		rng(t0, 10, 30);
		@(posedge clk);
		pb_n <= 1'b1;
		wt(2, 700);
		rng(t0, 485, 515);
		chk({31'h0, wake_n}, 32'h0);
		wt(9, 100);
		t0 = $time;
		wt(10, 300);
		t1 = $time;
		wt(4, 500);
		rng(t1, 220, 265);
		chk({31'h0, aux_pg}, 32'h1);
		wt(3, 700);
		rng(t0, 485, 515);
		rd(3'h6);
		chk(rd_q, 32'h1);
		wr(3'h6, 32'h1);
		rd(3'h6);
		chk(rd_q, 32'h0);
		wr(3'h0, 32'h0);
		@(posedge clk);
		cmd <= 1'b0;
		wt(5, 300);
		chk({25'h0, en}, 32'h6f);
		t0 = $time;
		wt(6, 100);
		rng(t0, 10, 30);
		chk({25'h0, en}, 32'h67);
		chk({31'h0, aux_pg}, 32'h1);
		wt(7, 300);
		#50;
		chk({25'h0, en}, 32'h60);
		chk({30'h0, main_pg, aux_pg}, 32'h1);
		rd(3'h5);
		chk({25'h0, rd_q[14:8]}, 32'h40);
		@(posedge clk);
		eager <= 1'b1;
		cmd <= 1'b1;
		wt(4, 1500);
		chk({25'h0, en}, 32'h7f);
		@(posedge clk);
		fault <= 7'h08;
		#500;
		chk({24'h0, main_pg, en}, 32'hff);
		@(posedge clk);
		fault <= 7'h09;
		wt(8, 1000);
		@(posedge clk);
		#1;
		chk({30'h0, main_pg, aux_pg}, 32'h0);
		@(posedge clk);
		fault <= 7'h00;
		usb <= 1'b1;
		wt(4, 3000);
		wr(3'h0, 32'h7);
		wt(5, 300);
		chk({27'h0, en[4:0]}, 32'h0);
		wt(8, 100);
		@(posedge clk);
		#1;
		chk({30'h0, main_pg, aux_pg}, 32'h0);
		rd(3'h0);
		chk({31'h0, rd_q[0]}, 32'h0);
		// reset pin low blocks a wake event in OFF
		@(posedge clk);
		usb <= 1'b0;
		hw_rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		usb <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk({25'h0, en}, 32'h0);
		@(posedge clk);
		hw_rst_n <= 1'b1;
		wr(3'h1, 32'h0);
		// mid-run reset restores the masks and outputs
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({30'h0, main_pg, aux_pg}, 32'h0);
		rd(3'h1);
		chk(rd_q, 32'h1403);
		close_out();
	end

	initial begin
		#400000;
		fail_count++;
		close_out();
	end
endmodule
